/* File: core/emp_pkg.sv */
// Package for the external memory port: constants, types and states
package emp_pkg;

  // ***********************************************
  // Widths and counts
  // ***********************************************
  localparam int unsigned DATA_W       = 24;
  localparam int unsigned ADDR_W_WIDE  = 24;
  localparam int unsigned ADDR_W_NARROW = 18;
  localparam int unsigned ATTR_N       = 4;
  localparam int unsigned WAIT_W       = 5;
  localparam logic [4:0]  WAIT_MAX     = 5'h1f;
  localparam int unsigned PRIO_OFF_BIT = 14;
  localparam logic [23:0] DATA_RST     = 24'h00_0000;
  localparam logic [23:0] ADDR_RST     = 24'h00_0000;
  localparam logic [4:0]  WAIT_RST     = 5'h00;

  // ***********************************************
  // Memory spaces and states
  // ***********************************************
  typedef enum logic [1:0] {
    EMP_SPACE_X = 2'h0,
    EMP_SPACE_Y = 2'h1,
    EMP_SPACE_P = 2'h2
  } emp_space_t;

  typedef enum logic [1:0] {
    EMP_IDLE  = 2'b00,
    EMP_START = 2'b01,
    EMP_WAIT  = 2'b11,
    EMP_DONE  = 2'b10
  } emp_state_t;

  // Core side access request
  typedef struct packed {
    logic        write;
    emp_space_t  space;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [3:0]  attr;
    logic [4:0]  wait_n;
  } emp_req_t;

  // Pin group with one enable per group
  typedef struct packed {
    logic [23:0] addr;
    logic        addr_oe;
    logic [23:0] data;
    logic        data_oe;
    logic [3:0]  attr;
    logic        attr_oe;
    logic        rd_n;
    logic        wr_n;
    logic        bs_n;
    logic        strobe_oe;
  } emp_pins_t;

endpackage : emp_pkg

/* File: core/emp_port.sv */
// External memory port: bus master sequencer driving the expansion pins
`timescale 1ns/1ns
`default_nettype none

module emp_port #(
  parameter int unsigned ADDR_W = emp_pkg::ADDR_W_WIDE
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Core request side
  input  wire emp_pkg::emp_req_t req_in,
  input  wire logic              req_valid_in,
  output logic                   req_ready_out,
  output logic [23:0]            rdata_out,
  output logic                   done_out,
  output logic [1:0]             space_out,
  // Arbitration and power states
  input  wire logic              bus_grant_in,
  input  wire logic              stop_in,
  input  wire logic              wait_mode_in,
  input  wire logic [23:0]       operating_mode_reg_in,
  input  wire logic              row_strobe_mode_in,
  input  wire logic              row_strobe_pol_in,
  // Far side
  input  wire logic              transfer_ack_n_in,
  input  wire logic [23:0]       data_in,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe_out,
  output logic [23:0]            data_out,
  output logic                   data_oe_out,
  output logic [3:0]             attribute_select_out,
  output logic                   attribute_select_oe_out,
  output logic                   rd_n_out,
  output logic                   wr_n_out,
  output logic                   bus_cycle_strobe_n_out,
  output logic                   strobe_oe_out
);

  // ***********************************************
  // Input synchronisers
  // ***********************************************
  // Acknowledge, grant and read data come from other masters and devices
  // with no clock relation; only the second stage feeds the sequencer, at the
  // cost of two cycles of latency on each
  logic        ta_s1_q;
  logic        ta_s2_q;
  logic        grant_s1_q;
  logic        grant_s2_q;
  logic [23:0] din_s1_q;
  logic [23:0] din_s2_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ta_s1_q    <= 1'b1;
      ta_s2_q    <= 1'b1;
      grant_s1_q <= 1'b0;
      grant_s2_q <= 1'b0;
      din_s1_q   <= emp_pkg::DATA_RST;
      din_s2_q   <= emp_pkg::DATA_RST;
    end else begin
      ta_s1_q    <= transfer_ack_n_in;
      ta_s2_q    <= ta_s1_q;
      grant_s1_q <= bus_grant_in;
      grant_s2_q <= grant_s1_q;
      din_s1_q   <= data_in;
      din_s2_q   <= din_s1_q;
    end
  end

  // ***********************************************
  // Attribute encoding
  // ***********************************************
  function automatic logic [3:0] attr_code(input logic [3:0] raw, input logic prio_off);
    logic [3:0] r;
    r = 4'h0;
    if (prio_off) begin
      r = raw;
    end else begin
      // Lowest index wins; at most one line active
      if (raw[0])      r = 4'h1;
      else if (raw[1]) r = 4'h2;
      else if (raw[2]) r = 4'h4;
      else if (raw[3]) r = 4'h8;
    end
    return r;
  endfunction : attr_code

  // ***********************************************
  // Sequencer
  // ***********************************************
  emp_pkg::emp_state_t state_q, state_d;
  emp_pkg::emp_req_t   cur_q, cur_d;
  logic [4:0]          cnt_q, cnt_d;
  logic                ta_seen_q, ta_seen_d;
  logic [23:0]         addr_q, addr_d;
  logic [23:0]         rdata_q, rdata_d;
  logic                done_q, done_d;
  logic                drove_q, drove_d;
  logic                master;
  logic                prio_off;

  assign master   = grant_s2_q & ~stop_in;
  assign prio_off = operating_mode_reg_in[emp_pkg::PRIO_OFF_BIT];

  // Acknowledge latches once seen, so a short pulse from a fast device still counts
  logic wait_over;
  logic ack_ok;
  logic complete;
  assign wait_over = (cnt_q == 5'h00);
  assign ack_ok    = ta_seen_q | ~ta_s2_q;
  assign complete  = (state_q == emp_pkg::EMP_WAIT) & wait_over & ack_ok;

  // One access: taken in idle, one start cycle carrying the bus strobe, then
  // the wait state counts the static waits down and holds until the
  // acknowledge has been seen; a one-cycle done state lets the attribute
  // lines drop before the next access may be taken
  always_comb begin
    state_d   = state_q;
    cur_d     = cur_q;
    cnt_d     = cnt_q;
    ta_seen_d = ta_seen_q;
    addr_d    = addr_q;
    done_d    = 1'b0;
    drove_d   = drove_q;
    unique case (state_q)
      emp_pkg::EMP_IDLE: begin
        // Wait mode holds the sequencer in idle, pins untouched; an access already under way runs on to done
        if (req_valid_in && master && !wait_mode_in) begin
          cur_d     = req_in;
          cnt_d     = req_in.wait_n;
          ta_seen_d = 1'b0;
          addr_d    = req_in.addr;
          drove_d   = req_in.write;
          state_d   = emp_pkg::EMP_START;
        end
      end
      emp_pkg::EMP_START: begin
        state_d = emp_pkg::EMP_WAIT;
      end
      emp_pkg::EMP_WAIT: begin
        if (!ta_s2_q) ta_seen_d = 1'b1;
        if (cnt_q != 5'h00) cnt_d = cnt_q - 5'h01;
        if (complete) begin
          done_d  = 1'b1;
          state_d = emp_pkg::EMP_DONE;
        end
      end
      emp_pkg::EMP_DONE: begin
        state_d = emp_pkg::EMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q   <= emp_pkg::EMP_IDLE;
      cur_q     <= '0;
      cnt_q     <= emp_pkg::WAIT_RST;
      ta_seen_q <= 1'b0;
      addr_q    <= emp_pkg::ADDR_RST;
      done_q    <= 1'b0;
      drove_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      cur_q     <= cur_d;
      cnt_q     <= cnt_d;
      ta_seen_q <= ta_seen_d;
      addr_q    <= addr_d;
      done_q    <= done_d;
      drove_q   <= drove_d;
    end
  end

  // ***********************************************
  // Read capture
  // ***********************************************
  // Synchronised data is two cycles old; the acknowledge path is at least as
  // slow, so the word taken is one the device drove inside the strobe window
  always_comb begin
    rdata_d = rdata_q;
    if (complete && !cur_q.write) begin
      rdata_d = din_s2_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= emp_pkg::DATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ***********************************************
  // Cycle decode
  // ***********************************************
  // Strobes and attribute lines follow the state, not the request, so a
  // change on req_in never reaches the pins in the middle of an access
  function automatic logic cycle_active(input emp_pkg::emp_state_t st);
    return (st == emp_pkg::EMP_START) || (st == emp_pkg::EMP_WAIT);
  endfunction : cycle_active

  logic in_cycle;
  logic busy;
  logic bs_half;
  assign in_cycle = cycle_active(state_q);
  // Done counts as busy so a new take never meets the falling strobes
  assign busy     = cycle_active(state_q) | (state_q == emp_pkg::EMP_DONE);

  // High phase of the start cycle gives the half-cycle strobe
  // Limitation: gated by the clock itself, so its width follows the duty cycle
  assign bs_half  = (state_q == emp_pkg::EMP_START) & clk_in;

  // ***********************************************
  // Attribute lines
  // ***********************************************
  logic       row_idle_hi;
  logic [3:0] attr_idle;
  logic [3:0] attr_act;
  // Active-low row strobes rest high; selects and active-high strobes rest low
  assign row_idle_hi = row_strobe_mode_in & ~row_strobe_pol_in;
  assign attr_idle   = {4{row_idle_hi}};

  // Row strobes bypass the priority scheme; selects go through it
  always_comb begin
    attr_act = attr_code(cur_q.attr, prio_off);
    if (row_strobe_mode_in) begin
      attr_act = cur_q.attr;
    end
  end

  // ***********************************************
  // Pin group
  // ***********************************************
  // One enable term for every pin group: reset, stop and lost grant all float
  logic               drive_ok;
  emp_pkg::emp_pins_t pins;
  assign drive_ok = master & ~rst_in;

  always_comb begin
    pins           = '0;
    pins.addr      = addr_q;
    pins.addr_oe   = drive_ok;
    pins.data      = cur_q.wdata;
    // Lines turn outward only for a write in progress; stop floats them
    pins.data_oe   = drive_ok & drove_q & cur_q.write & in_cycle;
    // Inactive level between accesses, polarity applied to both levels
    pins.attr      = in_cycle ? (attr_act ^ attr_idle) : attr_idle;
    pins.attr_oe   = drive_ok;
    pins.rd_n      = ~(in_cycle & ~cur_q.write);
    pins.wr_n      = ~(in_cycle & cur_q.write);
    pins.bs_n      = ~bs_half;
    pins.strobe_oe = drive_ok;
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  // Only the low address bits leave on the narrow variant
  assign addr_out                = pins.addr[ADDR_W-1:0];
  assign addr_oe_out             = pins.addr_oe;
  assign data_out                = pins.data;
  assign data_oe_out             = pins.data_oe;
  assign attribute_select_out    = pins.attr;
  assign attribute_select_oe_out = pins.attr_oe;
  assign rd_n_out                = pins.rd_n;
  assign wr_n_out                = pins.wr_n;
  assign bus_cycle_strobe_n_out  = pins.bs_n;
  assign strobe_oe_out           = pins.strobe_oe;

  // ***********************************************
  // Core side
  // ***********************************************
  // Ready is combinational so a request held at idle is taken at once
  assign req_ready_out = ~busy & master & ~wait_mode_in;
  assign rdata_out     = rdata_q;
  assign done_out      = done_q;
  assign space_out     = cur_q.space;

endmodule : emp_port

`default_nettype wire

/* File: bench/emp_port_properties.sv */
// Checker of pin timing for the external memory port
`timescale 1ns/1ns
`default_nettype none
module emp_port_props #(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic clk_in, rst_in, req_valid_in, req_ready_out, done_out, bus_grant_in, stop_in,
  input wire logic row_strobe_mode_in, row_strobe_pol_in, addr_oe_out, data_oe_out, attribute_select_oe_out,
  input wire logic rd_n_out, wr_n_out, bus_cycle_strobe_n_out, strobe_oe_out,
  input wire emp_pkg::emp_req_t req_in,
  input wire logic [23:0] operating_mode_reg_in,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [3:0] attribute_select_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic take, bs_hi_q;
  logic [6:0] cnt_q, cnt_d;
  logic [4:0] w_q, w_d;
  assign take = req_valid_in && req_ready_out;
  always_comb begin
    cnt_d = take ? 7'h0 : cnt_q + 7'(cnt_q != 7'h7f);
    w_d = take ? req_in.wait_n : w_q;
  end
  always_ff @(posedge clk_in) begin
    cnt_q <= cnt_d;
    w_q <= w_d;
  end
  // A posedge sample never sees the high-half strobe
  // Value from before the falling edge, free of the race with the gated strobe
  always_ff @(negedge clk_in) bs_hi_q <= $sampled(bus_cycle_strobe_n_out);
  AST_RST_FLOAT: assert property (disable iff (1'b0) rst_in |=>
    !(addr_oe_out | data_oe_out | attribute_select_oe_out | strobe_oe_out)) else $error("driven in reset");
  AST_ADDR: assert property (take |=> addr_out == $past(req_in.addr[ADDR_W-1:0])) else $error("bad address");
  AST_WRITE: assert property (take && req_in.write |=> !wr_n_out && rd_n_out && data_oe_out) else $error("no write");
  AST_READ: assert property (take && !req_in.write |=> !rd_n_out && wr_n_out && !data_oe_out) else $error("no read");
  AST_ADDR_HOLD: assert property (req_ready_out && !req_valid_in |=> $stable(addr_out)) else $error("addr moved");
  AST_ATTR_ONE: assert property (!(rd_n_out && wr_n_out) && attribute_select_oe_out && !row_strobe_mode_in &&
    !operating_mode_reg_in[14] |-> $onehot0(attribute_select_out) || $onehot0(~attribute_select_out))
    else $error("two selects");
  AST_ATTR_IDLE: assert property (rd_n_out && wr_n_out && !row_strobe_mode_in |-> attribute_select_out == 4'h0)
    else $error("select between accesses");
  AST_ATTR_ROW: assert property (take && row_strobe_mode_in |=> attribute_select_out ==
    ($past(row_strobe_pol_in) ? $past(req_in.attr) : ~$past(req_in.attr))) else $error("row polarity");
  AST_BS_HALF: assert property (strobe_oe_out |-> bus_cycle_strobe_n_out && (bs_hi_q || $past(take)))
    else $error("bad strobe");
  AST_BS_START: assert property (take |=> !bs_hi_q) else $error("no strobe");
  AST_MIN_WAIT: assert property (done_out |-> cnt_q >= 7'(w_q) + 7'h2) else $error("early done");
  AST_NOGRANT: assert property (!bus_grant_in [*4] |-> !req_ready_out && !addr_oe_out && !strobe_oe_out)
    else $error("drives without grant");
  AST_STOP: assert property (stop_in [*2] |-> !req_ready_out && !addr_oe_out && !data_oe_out) else $error("stop");
  cover property (take && req_in.write);
  cover property (done_out && w_q == 5'h1f);
  cover property (take && operating_mode_reg_in[14]);
endmodule : emp_port_props
bind emp_port emp_port_props #(.ADDR_W(ADDR_W)) emp_port_props_inst (.*);
`default_nettype wire

/* File: bench/emp_mem_model.sv */
// Behavioural external memory answering the port strobes
`timescale 1ns/1ns
`default_nettype none
module emp_mem_model (
  input  wire logic        clk_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [23:0] wdata_in,
  input  wire logic        wdata_oe_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic        strobe_oe_in,
  input  wire logic [3:0]  ack_dly_in,
  output logic [23:0]      data_out,
  output logic             ack_n_out
);
  logic [23:0] mem [256];
  logic [23:0] last_q = 24'h0000;
  logic [3:0]  cnt_q;
  logic        act;
  assign act = strobe_oe_in && !(rd_n_in && wr_n_in);
  // Released bus shows the inverse, so stale data never matches
  assign data_out = (act && !rd_n_in) ? mem[addr_in] : ~last_q;
  assign ack_n_out = !(act && cnt_q >= ack_dly_in);
  always_ff @(posedge clk_in) begin
    cnt_q <= act ? cnt_q + 4'(cnt_q != 4'hf) : 4'h0;
    if (act && !rd_n_in) last_q <= mem[addr_in];
    if (act && !wr_n_in && wdata_oe_in) mem[addr_in] <= wdata_in;
  end
endmodule : emp_mem_model
`default_nettype wire

/* File: bench/test_external_memory_port.sv */
// Self-checking bench for the external memory port
`timescale 1ns/1ns
`default_nettype none
module test_external_memory_port;
  logic clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, bus_grant_in = 1'b1, stop_in = 1'b0;
  logic wait_mode_in = 1'b0, row_strobe_mode_in = 1'b0, row_strobe_pol_in = 1'b1;
  logic [23:0] operating_mode_reg_in = 24'h0000;
  logic [3:0] ack_dly = 4'h0;
  emp_pkg::emp_req_t req_in = '0;
  logic req_ready_out, done_out, addr_oe_out, data_oe_out, attribute_select_oe_out, transfer_ack_n_in;
  logic rd_n_out, wr_n_out, bus_cycle_strobe_n_out, strobe_oe_out;
  logic [1:0] space_out;
  logic [3:0] attribute_select_out;
  logic [23:0] rdata_out, data_out, data_in, addr_out, mem_d;
  int err_total = 0, cmp_count = 0, seed = 32'h9235, cyc = 0;
  logic [2:0] knob [3] = '{3'b000, 3'b110, 3'b101};
  assign data_in = data_oe_out ? data_out : mem_d;
  emp_port emp_port_inst (.*);
  emp_mem_model emp_mem_model_inst (.clk_in, .addr_in(addr_out[7:0]), .wdata_in(data_out),
    .wdata_oe_in(data_oe_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .strobe_oe_in(strobe_oe_out),
    .ack_dly_in(ack_dly), .data_out(mem_d), .ack_n_out(transfer_ack_n_in));
  initial forever #50 clk_in = ~clk_in;
  task automatic print_verdict;
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic int min_lat(input logic [4:0] w, input logic [3:0] dly);
    // Start cycle plus static waits, or the acknowledge through its two-stage sync
    return (int'(w) + 3 > int'(dly) + 4) ? 3 + int'(w) : 4 + int'(dly);
  endfunction : min_lat
  task automatic go(output int n);
    req_valid_in = 1'b1;
    do @(negedge clk_in); while (req_ready_out !== 1'b1);
    @(posedge clk_in);
    #10 req_valid_in = 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (done_out !== 1'b1 && n < 200);
    @(posedge clk_in);
    #10;
  endtask : go
  initial begin
    logic [23:0] d;
    int n;
    repeat (16) @(posedge clk_in);
    #10 check("oe in reset", 24'h0, 24'({addr_oe_out, data_oe_out, attribute_select_oe_out, strobe_oe_out}));
    rst_in = 1'b0;
    for (int i = 0; i < 12; i++) begin
      d = 24'($random(seed));
      req_in.addr = 24'($random(seed));
      req_in.attr = 4'($random(seed));
      req_in.space = emp_pkg::emp_space_t'(2'(i % 3));
      operating_mode_reg_in[14] = i[1];
      row_strobe_mode_in = i[2] & i[0];
      row_strobe_pol_in = i[3];
      ack_dly = 4'($random(seed)) & 4'h7;
      for (int k = 0; k < 2; k++) begin
        req_in.write = (k == 0);
        req_in.wdata = d;
        req_in.wait_n = (i < 2) ? 5'(31 * i) : 5'($random(seed));
        go(n);
        check("latency", 24'(min_lat(req_in.wait_n, ack_dly)), 24'(n));
        check("space", 24'(req_in.space), 24'(space_out));
      end
      check("read data", d, rdata_out);
    end
    for (int k = 0; k < 3; k++) begin
      {bus_grant_in, stop_in, wait_mode_in} = knob[k];
      repeat (3) @(posedge clk_in);
      #10 req_valid_in = 1'b1;
      repeat (4) @(negedge clk_in);
      check("refused", 24'h0, 24'(req_ready_out));
      if (k < 2) check("floated", 24'h0, 24'({addr_oe_out, strobe_oe_out}));
      @(posedge clk_in);
      #10 {bus_grant_in, stop_in, wait_mode_in} = 3'b100;
      go(n);
      check("resumed", 24'h1, 24'(n < 200));
    end
    print_verdict();
  end
endmodule : test_external_memory_port
`default_nettype wire
